// ==== hdl/scc_defines.svh ====
// Constants for the serial status report and calibration command block.
// How it works
// R1: UART 9600 baud, 8N1, both directions.
// R2: New status report starts every 2 seconds.
// R3: Report order: concentration, range, span, alarms.
// R4: Each item ends with CR then LF.
// R5: Autospan and autozero commands start calibration immediately.
// R6: Pause toggle command inverts periodic reporting.
// R7: Controller checks contact open, holds zero request.
// R8: Controller drops zero request when contact closes.
// R9: Controller then runs span request the same way.
// R10: Contact reopens only when calibration finished.
// R11: Contact open means analysing and sampling requests.
// R12: Requests during calibration ignored, not stored.
// R13: Request still held at finish repeats calibration.
// R14: Contact closed throughout zero and span calibration.
// R15: Unknown commands are discarded without state change.
// R16: Serial calibration commands ignored while calibrating.
`ifndef SCC_DEFINES_SVH
`define SCC_DEFINES_SVH
`define SCC_CLK_HZ        25000000
`define SCC_BAUD          9600
`define SCC_BIT_CYCLES    (`SCC_CLK_HZ / `SCC_BAUD)
`define SCC_REPORT_SEC    2
`define SCC_REPORT_CYCLES (`SCC_REPORT_SEC * `SCC_CLK_HZ)
`define SCC_CH_CR         8'h0d
`define SCC_CH_LF         8'h0a
`define SCC_CH_SP         8'h20
`define SCC_CH_ZERO       8'h30
`define SCC_CH_DASH       8'h2d
`define SCC_CH_PCT        8'h25
`define SCC_CH_A          8'h61
`define SCC_CH_S          8'h73
`define SCC_CH_Z          8'h7a
`define SCC_CH_T          8'h74
`define SCC_TXT_PPM       24'h50504d
`define SCC_TXT_UPPER     24'h484920
`define SCC_TXT_MIDDLE    24'h4d4544
`define SCC_TXT_BOTTOM    24'h4c4f20
`define SCC_TXT_AL        24'h414c2d
`define SCC_TXT_DIS       64'h44495341424c4544
`define SCC_TXT_ON        16'h4f4e
`endif

// ==== hdl/scc_pkg.sv ====
// Types for the serial status report and calibration command block.
package scc_pkg;
	typedef struct packed {
		logic [23:0] conc_bcd;
		logic        conc_pct;
		logic [1:0]  range_sel;
		logic [23:0] span_bcd;
		logic [1:0]  alarm_off;
		logic [1:0]  alarm_trip;
	} scc_status_t;
	typedef enum logic [1:0] {CAL_OPEN = 2'b00, CAL_ZERO = 2'b01, CAL_SPAN = 2'b11} scc_cal_t;
	typedef enum logic [1:0] {GEN_IDLE = 2'b00, GEN_TEXT = 2'b01, GEN_CR = 2'b11, GEN_LF = 2'b10} scc_gen_t;
endpackage

// ==== hdl/scc_top.sv ====
// FIFO and top level of the serial status report and calibration command block.
`timescale 1ns/10ps
`default_nettype none
`include "scc_defines.svh"

module scc_fifo #(parameter int W = 8, parameter int D = 8) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         reset_i,
	// Fill side
	input  wire logic         in_valid_i,
	input  wire logic [W-1:0] in_data_i,
	output logic              in_ready_o,
	// Drain side
	output logic              out_valid_o,
	output logic [W-1:0]      out_data_o,
	input  wire logic         out_ready_i
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_ff, rd_ff;
	logic [AW:0]   cnt_ff;
	logic          push, pop;
	assign in_ready_o  = (cnt_ff != (AW+1)'(D));
	assign out_valid_o = (cnt_ff != '0);
	assign out_data_o  = mem[rd_ff];
	assign push = in_valid_i & in_ready_o;
	assign pop  = out_valid_o & out_ready_i;
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ff] <= in_data_i;
		end
	end
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wr_ff <= (wr_ff == AW'(D-1)) ? '0 : wr_ff + 1'b1;
			end
			if (pop) begin
				rd_ff <= (rd_ff == AW'(D-1)) ? '0 : rd_ff + 1'b1;
			end
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // scc_fifo

module scc_top import scc_pkg::*; #(
	parameter int REPORT_CYCLES = `SCC_REPORT_CYCLES,
	parameter int BIT_CYCLES    = `SCC_BIT_CYCLES,
	parameter int FIFO_DEPTH    = 8
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	// Serial link
	input  wire logic        rxd_i,
	output logic             txd_o,
	// Measurement status for the report, and report enable
	input  wire scc_status_t status_i,
	output logic             report_on_o,
	// Remote calibration pins
	input  wire logic        remote_zero_i,
	input  wire logic        remote_span_i,
	output logic             cal_contact_o,
	// Calibration engine
	output logic             cal_zero_o,
	output logic             cal_span_o,
	input  wire logic        cal_done_i
);
	logic [2:0] rx_sync_ff, zero_sync_ff, span_sync_ff;
	logic       rx_busy_ff, rx_strobe_ff;
	logic [15:0] rx_cnt_ff;
	logic [3:0]  rx_bit_ff;
	logic [7:0]  rx_sh_ff;
	logic [15:0] last2_ff;
	logic [1:0]  nchar_ff;
	logic        cmd_zero_ff, cmd_span_ff;
	scc_cal_t    cal_ff;
	scc_gen_t    gen_ff;
	scc_status_t snap_ff;
	logic [31:0] period_ff;
	logic [2:0]  item_ff;
	logic [3:0]  pos_ff;
	logic [8:0]  tb;
	logic        f_valid, f_ready, q_valid, q_ready;
	logic [7:0]  f_data, q_data;
	logic [9:0]  tx_sh_ff;
	logic [3:0]  tx_left_ff;
	logic [15:0] tx_cnt_ff;

	// Text constants as named values so that single characters can be selected from them.
	localparam logic [23:0] TXT_PPM = `SCC_TXT_PPM;
	localparam logic [23:0] TXT_AL  = `SCC_TXT_AL;
	localparam logic [63:0] TXT_DIS = `SCC_TXT_DIS;
	localparam logic [15:0] TXT_ON  = `SCC_TXT_ON;

	function automatic logic [7:0] dig(input logic [23:0] v, input logic [3:0] k);
		return `SCC_CH_ZERO + {4'h0, v[(5 - int'(k)) * 4 +: 4]};
	endfunction

	// Returns {more, byte} for position pos of report item item.
	function automatic logic [8:0] text_byte(input logic [2:0] item, input logic [3:0] pos, input scc_status_t s);
		logic [8:0] r;
		logic [23:0] rng;
		r = '0;
		rng = (s.range_sel == 2'd2) ? `SCC_TXT_UPPER : (s.range_sel == 2'd1) ? `SCC_TXT_MIDDLE : `SCC_TXT_BOTTOM;
		case (item)
			3'd0: begin
				if (pos < 4'd6) r = {1'b1, dig(s.conc_bcd, pos)};
				else if (pos == 4'd6) r = {1'b1, `SCC_CH_SP};
				else if (s.conc_pct) r = (pos == 4'd7) ? {1'b1, `SCC_CH_PCT} : 9'h0;
				else if (pos < 4'd10) r = {1'b1, TXT_PPM[(9 - int'(pos)) * 8 +: 8]};
			end
			3'd1: begin
				if (pos < 4'd3 && rng[(2 - int'(pos)) * 8 +: 8] != `SCC_CH_SP) r = {1'b1, rng[(2 - int'(pos)) * 8 +: 8]};
			end
			3'd2: begin
				if (pos == 4'd0) r = {1'b1, `SCC_CH_ZERO};
				else if (pos == 4'd1) r = {1'b1, `SCC_CH_DASH};
				else if (pos < 4'd8) r = {1'b1, dig(s.span_bcd, pos - 4'd2)};
				else if (pos == 4'd8) r = {1'b1, `SCC_CH_SP};
				else if (s.conc_pct) r = (pos == 4'd9) ? {1'b1, `SCC_CH_PCT} : 9'h0;
				else if (pos < 4'd12) r = {1'b1, TXT_PPM[(11 - int'(pos)) * 8 +: 8]};
			end
			default: begin
				if ((item < 3'd5) ? s.alarm_off[item[0] ? 0 : 1] : s.alarm_trip[item[0] ? 0 : 1]) begin
					if (pos < 4'd3) r = {1'b1, TXT_AL[(2 - int'(pos)) * 8 +: 8]};
					else if (pos == 4'd3) r = {1'b1, `SCC_CH_ZERO + ((item == 3'd3 || item == 3'd5) ? 8'h01 : 8'h02)};
					else if (pos == 4'd4) r = {1'b1, `SCC_CH_SP};
					else if (item < 3'd5 && pos < 4'd13) r = {1'b1, TXT_DIS[(12 - int'(pos)) * 8 +: 8]};
					else if (item >= 3'd5 && pos < 4'd7) r = {1'b1, TXT_ON[(6 - int'(pos)) * 8 +: 8]};
				end
			end
		endcase
		return r;
	endfunction

	// Pin synchronisers; stage 0 is read only by stage 1.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rx_sync_ff   <= 3'h7;
			zero_sync_ff <= 3'h0;
			span_sync_ff <= 3'h0;
		end else begin
			rx_sync_ff   <= {rx_sync_ff[1:0], rxd_i};
			zero_sync_ff <= {zero_sync_ff[1:0], remote_zero_i};
			span_sync_ff <= {span_sync_ff[1:0], remote_span_i};
		end
	end

	// Receiver samples mid bit, 8 data, no parity, 1 stop.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rx_busy_ff   <= 1'b0;
			rx_strobe_ff <= 1'b0;
			rx_cnt_ff    <= '0;
			rx_bit_ff    <= '0;
			rx_sh_ff     <= '0;
		end else begin
			rx_strobe_ff <= 1'b0;
			if (!rx_busy_ff) begin
				if (!rx_sync_ff[1]) begin
					rx_busy_ff <= 1'b1;
					rx_cnt_ff  <= 16'(BIT_CYCLES / 2);
					rx_bit_ff  <= '0;
				end
			end else if (rx_cnt_ff != '0) begin
				rx_cnt_ff <= rx_cnt_ff - 1'b1;
			end else begin
				rx_cnt_ff <= 16'(BIT_CYCLES - 1);
				rx_bit_ff <= rx_bit_ff + 1'b1;
				if (rx_bit_ff == 4'd0 && rx_sync_ff[2]) begin
					rx_busy_ff <= 1'b0;
				end else if (rx_bit_ff < 4'd9) begin
					rx_sh_ff <= {rx_sync_ff[2], rx_sh_ff[7:1]};
				end else begin
					rx_busy_ff   <= 1'b0;
					rx_strobe_ff <= rx_sync_ff[2]; // [R1]
				end
			end
		end
	end

	// Command parser: two characters then Enter.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			last2_ff    <= '0;
			nchar_ff    <= '0;
			cmd_zero_ff <= 1'b0;
			cmd_span_ff <= 1'b0;
			report_on_o <= 1'b1;
		end else begin
			cmd_zero_ff <= 1'b0;
			cmd_span_ff <= 1'b0;
			if (rx_strobe_ff) begin
				if (rx_sh_ff == `SCC_CH_CR) begin
					nchar_ff <= '0;
					if (nchar_ff == 2'd2) begin
						if (last2_ff == {`SCC_CH_A, `SCC_CH_S}) cmd_span_ff <= 1'b1; // [R5]
						else if (last2_ff == {`SCC_CH_A, `SCC_CH_Z}) cmd_zero_ff <= 1'b1; // [R5]
						else if (last2_ff == {`SCC_CH_S, `SCC_CH_T}) report_on_o <= !report_on_o; // [R6]
					end // [R15]
				end else if (rx_sh_ff != `SCC_CH_LF) begin
					last2_ff <= {last2_ff[7:0], rx_sh_ff};
					nchar_ff <= (nchar_ff == 2'd3) ? 2'd3 : nchar_ff + 1'b1;
				end
			end
		end
	end

	// Calibration sequencer and contact.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cal_ff        <= CAL_OPEN;
			cal_contact_o <= 1'b0;
			cal_zero_o    <= 1'b0;
			cal_span_o    <= 1'b0;
		end else begin
			case (cal_ff)
				CAL_OPEN: begin
					// Requests are only looked at here, so none is kept for later. [R11] [R12] [R16]
					if (zero_sync_ff[2] || cmd_zero_ff) begin
						cal_ff        <= CAL_ZERO;
						cal_contact_o <= 1'b1; // [R14]
						cal_zero_o    <= 1'b1;
					end else if (span_sync_ff[2] || cmd_span_ff) begin
						cal_ff        <= CAL_SPAN;
						cal_contact_o <= 1'b1; // [R14]
						cal_span_o    <= 1'b1;
					end
				end
				default: begin
					if (cal_done_i) begin
						// Opens for at least one cycle, then a held request runs again. [R10] [R13]
						cal_ff        <= CAL_OPEN;
						cal_contact_o <= 1'b0;
						cal_zero_o    <= 1'b0;
						cal_span_o    <= 1'b0;
					end
				end
			endcase
		end
	end

	// Two second report timer and text generator.
	assign tb      = text_byte(item_ff, pos_ff, snap_ff);
	assign f_valid = (gen_ff == GEN_CR) || (gen_ff == GEN_LF) || (gen_ff == GEN_TEXT && tb[8]);
	assign f_data  = (gen_ff == GEN_CR) ? `SCC_CH_CR : (gen_ff == GEN_LF) ? `SCC_CH_LF : tb[7:0];

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			period_ff <= '0;
			gen_ff    <= GEN_IDLE;
			item_ff   <= '0;
			pos_ff    <= '0;
			snap_ff   <= '0;
		end else begin
			period_ff <= (period_ff == 32'(REPORT_CYCLES - 1)) ? '0 : period_ff + 1'b1; // [R2]
			case (gen_ff)
				GEN_IDLE: begin
					if (period_ff == '0 && report_on_o) begin // [R2] [R6]
						gen_ff  <= GEN_TEXT;
						item_ff <= '0;
						pos_ff  <= '0;
						snap_ff <= status_i;
					end
				end
				GEN_TEXT: begin
					if (!tb[8]) begin
						if (pos_ff != '0) gen_ff <= GEN_CR;
						else if (item_ff == 3'd6) gen_ff <= GEN_IDLE;
						else item_ff <= item_ff + 1'b1; // [R3]
					end else if (f_ready) begin
						pos_ff <= pos_ff + 1'b1;
					end
				end
				GEN_CR: begin
					if (f_ready) gen_ff <= GEN_LF; // [R4]
				end
				default: begin
					if (f_ready) begin // [R4]
						pos_ff <= '0;
						if (item_ff == 3'd6) gen_ff <= GEN_IDLE;
						else begin
							gen_ff  <= GEN_TEXT;
							item_ff <= item_ff + 1'b1; // [R3]
						end
					end
				end
			endcase
		end
	end

	scc_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
		.clk_i       (clk_i),
		.reset_i     (reset_i),
		.in_valid_i  (f_valid),
		.in_data_i   (f_data),
		.in_ready_o  (f_ready),
		.out_valid_o (q_valid),
		.out_data_o  (q_data),
		.out_ready_i (q_ready)
	);

	// Transmitter, LSB first with start and stop bit.
	assign q_ready = (tx_left_ff == '0);
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			tx_sh_ff   <= '1;
			tx_left_ff <= '0;
			tx_cnt_ff  <= '0;
			txd_o      <= 1'b1;
		end else if (tx_left_ff == '0) begin
			txd_o <= 1'b1;
			if (q_valid) begin
				tx_sh_ff   <= {1'b1, q_data, 1'b0}; // [R1]
				tx_left_ff <= 4'd10;
				tx_cnt_ff  <= '0;
			end
		end else if (tx_cnt_ff == '0) begin
			txd_o      <= tx_sh_ff[0];
			tx_sh_ff   <= {1'b1, tx_sh_ff[9:1]};
			tx_cnt_ff  <= 16'(BIT_CYCLES - 1);
		end else begin
			tx_cnt_ff <= tx_cnt_ff - 1'b1;
			if (tx_cnt_ff == 16'd1) tx_left_ff <= tx_left_ff - 1'b1;
		end
	end
endmodule // scc_top
`default_nettype wire

// ==== sim/scc_top_props.sv ====
// Port assertions for the status report and calibration block.
`timescale 1ns/10ps
`default_nettype none
module scc_top_props import scc_pkg::*; #(
	parameter int REPORT_CYCLES = 20000,
	parameter int BIT_CYCLES    = 16,
	parameter int FIFO_DEPTH    = 8
) (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        reset_i,
	// Serial and status
	input wire logic        rxd_i,
	input wire logic        txd_o,
	input wire scc_status_t status_i,
	input wire logic        report_on_o,
	// Calibration
	input wire logic        remote_zero_i,
	input wire logic        remote_span_i,
	input wire logic        cal_contact_o,
	input wire logic        cal_zero_o,
	input wire logic        cal_span_o,
	input wire logic        cal_done_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	int   run_ff;
	logic txd_ff;
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			run_ff <= BIT_CYCLES;
			txd_ff <= 1'b1;
		end else begin
			run_ff <= (txd_o != txd_ff) ? 1 : run_ff + ((run_ff < BIT_CYCLES) ? 1 : 0);
			txd_ff <= txd_o;
		end
	end
	property p_bit; (txd_o != txd_ff) |-> run_ff >= BIT_CYCLES; endproperty
	a_bit: assert property (p_bit) else $error("serial level shorter than a bit");
	property p_contact; cal_contact_o == (cal_zero_o || cal_span_o); endproperty
	a_contact: assert property (p_contact) else $error("contact differs from calibration");
	property p_reopen; $fell(cal_contact_o) |-> $past(cal_done_i); endproperty
	a_reopen: assert property (p_reopen) else $error("contact opened without done");
	property p_done; cal_contact_o && cal_done_i |=> !cal_contact_o; endproperty
	a_done: assert property (p_done) else $error("contact held after done");
	property p_hold; cal_contact_o && !cal_done_i |=> $stable({cal_zero_o, cal_span_o}); endproperty
	a_hold: assert property (p_hold) else $error("calibration changed while running");
	property p_zero; (remote_zero_i && !cal_contact_o) [*4] |-> ##[1:2] cal_zero_o; endproperty
	a_zero: assert property (p_zero) else $error("zero request not taken");
	property p_span; (remote_span_i && !remote_zero_i && !cal_contact_o) [*4] |-> ##[1:2] cal_span_o; endproperty
	a_span: assert property (p_span) else $error("span request not taken");
	property p_one; !(cal_zero_o && cal_span_o); endproperty
	a_one: assert property (p_one) else $error("zero and span at once");
	c_zero: cover property ($rose(cal_zero_o));
	c_span: cover property ($rose(cal_span_o));
	c_pause: cover property ($fell(report_on_o));
	c_again: cover property ($fell(cal_contact_o) ##[1:3] $rose(cal_contact_o));
endmodule // scc_top_props
bind scc_top scc_top_props #(.REPORT_CYCLES(REPORT_CYCLES), .BIT_CYCLES(BIT_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) u_props (
	.clk_i(clk_i), .reset_i(reset_i), .rxd_i(rxd_i), .txd_o(txd_o), .status_i(status_i),
	.report_on_o(report_on_o), .remote_zero_i(remote_zero_i), .remote_span_i(remote_span_i),
	.cal_contact_o(cal_contact_o), .cal_zero_o(cal_zero_o), .cal_span_o(cal_span_o), .cal_done_i(cal_done_i));
`default_nettype wire

// ==== sim/scc_host.sv ====
// Host model: serial terminal and remote calibration controller.
`timescale 1ns/10ps
`default_nettype none
module scc_host #(parameter int BIT_CYCLES = 16) (
	// Clock
	input  wire logic clk_i,
	// Serial link
	input  wire logic txd_i,
	output logic      rxd_o,
	// Remote calibration
	input  wire logic cal_contact_i,
	output logic      zero_o,
	output logic      span_o
);
	logic [7:0] got[$];
	int         stamp[$];
	int         cyc = 0;
	int         frame_err = 0;
	logic [7:0] sh;
	initial begin
		rxd_o = 1'b1;
		{zero_o, span_o} = 2'b00;
	end
	always @(posedge clk_i) cyc++;
	// Mid-bit sampling, 8 data bits LSB first, one stop bit.
	always @(negedge txd_i) begin : rx
		int t;
		t = cyc;
		repeat (BIT_CYCLES / 2) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYCLES) @(posedge clk_i);
			sh[i] = txd_i;
		end
		repeat (BIT_CYCLES) @(posedge clk_i);
		if (txd_i !== 1'b1) frame_err++;
		got.push_back(sh);
		stamp.push_back(t);
	end
	// Sends one 8N1 frame.
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_i);
			#1 rxd_o = f[i];
			repeat (BIT_CYCLES - 1) @(posedge clk_i);
		end
	endtask
	task automatic send_line(input string s);
		for (int i = 0; i < s.len(); i++) send_byte(s[i]);
		send_byte(8'h0d);
	endtask
	// Zero then span, each held until the contact closes, then dropped.
	task automatic cal_protocol();
		for (int k = 0; k < 2; k++) begin
			for (int n = 0; n < 500 && cal_contact_i !== 1'b0; n++) @(posedge clk_i);
			@(posedge clk_i);
			#1 {zero_o, span_o} = k ? 2'b01 : 2'b10;
			for (int n = 0; n < 500 && cal_contact_i !== 1'b1; n++) @(posedge clk_i);
			#1 {zero_o, span_o} = 2'b00;
		end
	endtask
	task automatic set_req(input logic z, input logic s);
		@(posedge clk_i);
		#1 {zero_o, span_o} = {z, s};
	endtask
endmodule // scc_host
`default_nettype wire

// ==== sim/tb_scc_top.sv ====
// Testbench for the status report and calibration block.
`timescale 1ns/10ps
`default_nettype none
module tb_scc_top import scc_pkg::*;;
	localparam int RC = 12000;
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        cal_done_i = 1'b0;
	scc_status_t status_i = {24'h001234, 1'b0, 2'd2, 24'h010000, 2'b01, 2'b10};
	logic        rxd, txd, report_on_o, zero, span, cal_contact_o, cal_zero_o, cal_span_o;
	int          bad_count = 0;
	int          comparisons = 0;
	int          cycles = 0;
	int          busy = 0;
	int          cal_len = 24;
	always #20 clk_i = ~clk_i;
	scc_top #(.REPORT_CYCLES(RC), .BIT_CYCLES(16), .FIFO_DEPTH(8)) DUT (.clk_i(clk_i), .reset_i(reset_i),
		.rxd_i(rxd), .txd_o(txd), .status_i(status_i), .report_on_o(report_on_o), .remote_zero_i(zero),
		.remote_span_i(span), .cal_contact_o(cal_contact_o), .cal_zero_o(cal_zero_o),
		.cal_span_o(cal_span_o), .cal_done_i(cal_done_i));
	scc_host #(.BIT_CYCLES(16)) host (.clk_i(clk_i), .txd_i(txd), .rxd_o(rxd), .cal_contact_i(cal_contact_o),
		.zero_o(zero), .span_o(span));
	// Calibration engine ends each run after cal_len cycles; also the run limit.
	always @(posedge clk_i) begin
		cycles++;
		busy = cal_contact_o ? busy + 1 : 0;
		#1 cal_done_i = (busy == cal_len);
		if (cycles == 70000) begin
			bad_count++;
			print_verdict();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic t_report();
		string e;
		e = "001234 PPM\015\nHI\015\n0-010000 PPM\015\nAL-1 DISABLED\015\nAL-2 ON\015\n";
		for (int n = 0; n < 30000 && host.got.size() < 2 * e.len(); n++) @(posedge clk_i);
		for (int i = 0; i < 2 * e.len(); i++) check("report byte", host.got[i], e[i % e.len()]);
		check("report period", host.stamp[e.len()] - host.stamp[0], RC);
		check("stop bits", host.frame_err, 0);
		$display("report test done");
	endtask
	task automatic t_pause();
		host.send_line("st");
		wait_cyc(4);
		check("reports paused", report_on_o, 0);
		host.got.delete();
		wait_cyc(RC + 200);
		check("bytes while paused", host.got.size(), 0);
		host.send_line("st");
		wait_cyc(4);
		check("reports resumed", report_on_o, 1);
		wait_cyc(RC + 2000);
		check("bytes after resume", host.got.size() > 0, 1);
		$display("pause test done");
	endtask
	task automatic t_serial_cal();
		cal_len = 600;
		host.send_line("zz");
		wait_cyc(4);
		check("unknown line", {report_on_o, cal_contact_o}, 2'b10);
		host.send_line("az");
		wait_cyc(1);
		check("zero by command", {cal_contact_o, cal_zero_o, cal_span_o}, 3'b110);
		host.send_line("as");
		wait_cyc(1);
		check("span while busy", {cal_contact_o, cal_zero_o, cal_span_o}, 3'b110);
		wait_cyc(200);
		check("zero finished", cal_contact_o, 0);
		host.send_line("as");
		wait_cyc(1);
		check("span by command", {cal_contact_o, cal_zero_o, cal_span_o}, 3'b101);
		wait_cyc(620);
		cal_len = 24;
		$display("serial calibration test done");
	endtask
	task automatic t_remote();
		host.cal_protocol();
		wait_cyc(30);
		check("open after protocol", cal_contact_o, 0);
		host.set_req(1, 0);
		wait_cyc(6);
		check("zero by pin", {cal_contact_o, cal_zero_o, cal_span_o}, 3'b110);
		host.set_req(0, 1);
		wait_cyc(10);
		host.set_req(0, 0);
		wait_cyc(30);
		check("request in calibration", cal_contact_o, 0);
		host.set_req(1, 0);
		wait_cyc(34);
		check("held request repeats", {cal_contact_o, cal_zero_o}, 2'b11);
		host.set_req(0, 0);
		wait_cyc(30);
		check("contact reopened", cal_contact_o, 0);
		$display("remote calibration test done");
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		#1 reset_i = 1'b0;
		t_report();
		t_pause();
		t_serial_cal();
		t_remote();
		print_verdict();
	end
endmodule // tb_scc_top
`default_nettype wire
